// >>> include/timer_pkg.sv
// Shared constants for the cascadable up/down timer pairs
`default_nettype none
package timer_pkg;
  // Sizes
  localparam int          NUM_TIMERS      = 4;
  localparam int          CNT_W           = 16;
  localparam int          CTRL_W          = 8;
  localparam int          ADDR_W          = 8;
  // Register byte offsets
  localparam logic [7:0]  OFF_CTRL_BASE   = 8'h00;  // Four control words, 0x00..0x0C
  localparam logic [7:0]  OFF_COUNT_BASE  = 8'h10;  // Four count words, 0x10..0x1C
  localparam logic [7:0]  OFF_INT_STATUS  = 8'h20;
  localparam logic [7:0]  OFF_INT_CLEAR   = 8'h24;
  localparam logic [7:0]  OFF_INT_ENABLE  = 8'h28;
  // Control word fields
  localparam int          CTRL_CONCAT_BIT = 7;      // Upper timer of a pair only
  localparam int          CTRL_DIR_BIT    = 6;      // 1 counts up, 0 counts down
  localparam int          CTRL_EN_BIT     = 5;
  localparam int          CTRL_SRC_LO     = 3;      // Two bits, 4:3
  localparam int          CTRL_PRE_LO     = 0;      // Three bits, 2:0
  // Clock source select codes
  localparam logic [1:0]  SRC_INTERNAL    = 2'h0;
  localparam logic [1:0]  SRC_PIN_RISE    = 2'h1;
  localparam logic [1:0]  SRC_PIN_FALL    = 2'h2;
  localparam logic [1:0]  SRC_PIN_BOTH    = 2'h3;
  // Pending-flag step points
  localparam logic [15:0] UP_FLAG_VALUE   = 16'hFFFE;
  localparam logic [15:0] DOWN_FLAG_VALUE = 16'h0001;
  // Reset values
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [15:0] COUNT_RESET     = 16'h0000;
  localparam logic [3:0]  INT_RESET       = 4'h0;
endpackage : timer_pkg
`default_nettype wire

// >>> include/timer_ctl_if.sv
// Control and status bundle between the timer core and one counter
`timescale 1ns/1ps
`default_nettype none
interface timer_ctl_if;
  logic        tick;      // One-cycle count step
  logic        up;        // Direction for this step
  logic        load;      // Software write of the count
  logic [15:0] load_val;
  logic [15:0] count;
  logic        ovf;       // Pending-flag step, same cycle as tick
  modport ctl (output tick, up, load, load_val, input count, ovf);
  modport cnt (input tick, up, load, load_val, output count, ovf);
endinterface : timer_ctl_if
`default_nettype wire

// >>> src/updown_counter.sv
// One 16-bit up/down counter with its flag-step detector
`timescale 1ns/1ps
`default_nettype none
module updown_counter
  import timer_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  timer_ctl_if.cnt bus
);
  logic [15:0] count_q;

  // Software load takes priority over a count step
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_q <= COUNT_RESET;
    end else if (bus.load) begin
      count_q <= bus.load_val;
    end else if (bus.tick) begin
      count_q <= bus.up ? count_q + 16'h0001 : count_q - 16'h0001;
    end
  end

  // Flag step: FFFE->FFFF up, 0001->0000 down; the 0000->FFFF wrap does not flag
  assign bus.ovf   = bus.tick && !bus.load &&
                     (bus.up ? (count_q == UP_FLAG_VALUE)     // [RL3]
                             : (count_q == DOWN_FLAG_VALUE)); // [RL4]
  assign bus.count = count_q;

  a_up_flag_step: assert property (  // [RL3]
    @(posedge clk) disable iff (reset)
    (bus.tick && bus.up && !bus.load && count_q == 16'hFFFE)
      |-> bus.ovf ##1 (count_q == 16'hFFFF))
    else $error("up step FFFE to FFFF did not flag");
  a_down_flag_step: assert property (  // [RL4]
    @(posedge clk) disable iff (reset)
    (bus.tick && !bus.up && !bus.load && count_q == 16'h0001)
      |-> bus.ovf ##1 (count_q == 16'h0000))
    else $error("down step 0001 to 0000 did not flag");
  a_no_wrap_flag: assert property (  // [RL4]
    @(posedge clk) disable iff (reset)
    (!bus.up && count_q == 16'h0000) |-> !bus.ovf)
    else $error("down wrap 0000 to FFFF flagged");
endmodule : updown_counter
`default_nettype wire

// >>> src/cascadable_updown_timer_pairs.sv
// Four up/down timers in two cascadable pairs behind an APB slave
`timescale 1ns/1ps
`default_nettype none
// What this block does
// (RL1) Pair one concatenated: timer one's direction bit steers timers one and two.
// (RL2) Pair two concatenated: timer three's direction bit steers timers three and four.
// (RL3) Counting up, the pending flag sets on the step FFFE to FFFF.
// (RL4) Counting down, flag sets on 0001 to 0000, never on 0000 to FFFF.
// (RL5) Concatenated, timer two steps on timer one's overflow, skipping its prescaler.
// (RL6) Timer two's prescaler is fed by the source select on control bits 4:3.
// (RL7) Control bit 7 selects prescaler output or timer one's overflow as clock.
module cascadable_updown_timer_pairs
  import timer_pkg::*;
#(
  parameter int PRE_W = 7  // Prescaler depth, divide up to 2^7 for any PRE_W in 7..16
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic [3:0]  ext_clk,
  output var  logic        irq
);

  if (PRE_W < 7 || PRE_W > 16) begin : g_bad_pre
    $error("PRE_W must lie in 7..16 to serve divide-by-128");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Returns {hit, index} for a block of four aligned words at base
  function automatic logic [2:0] word_sel(input logic [7:0] a, input logic [7:0] base);
    logic hit;
    hit = (a[7:4] == base[7:4]) && (a[1:0] == 2'h0);
    return {hit, a[3:2]};
  endfunction : word_sel

  // Prescaler mask for a divide by 2^n
  function automatic logic [PRE_W-1:0] pre_mask(input logic [2:0] n);
    logic [PRE_W-1:0] m;
    m = '0;
    for (int b = 0; b < 7; b++) begin
      if (b < int'(n)) begin
        m[b] = 1'b1;
      end
    end
    return m;
  endfunction : pre_mask

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [7:0]  ctl_q [NUM_TIMERS];
  logic [3:0]  sts_q;
  logic [3:0]  sts_d;
  logic [3:0]  ien_q;
  logic [3:0]  ext_s1_q;
  logic [3:0]  ext_s2_q;
  logic [3:0]  ext_s3_q;
  logic [15:0] cnt_w   [NUM_TIMERS];
  logic [3:0]  ovf_w;
  logic [3:0]  tick_w;
  logic [3:0]  up_w;
  logic [3:0]  pre_tick;
  logic [3:0]  src_evt;
  logic [3:0]  load_w;
  logic [2:0]  ctl_hit;
  logic [2:0]  cnt_hit;
  logic        wr_en;

  timer_ctl_if tif [NUM_TIMERS] ();

  ////////////////////////////////////////////////////////////////////////////
  // APB slave

  // No wait state: pready rises in the first access cycle, read data ready
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable && !pready;
    end
  end

  assign ctl_hit = word_sel(paddr, OFF_CTRL_BASE);
  assign cnt_hit = word_sel(paddr, OFF_COUNT_BASE);
  assign wr_en   = psel && penable && pready && pwrite;

  // Read data and error captured in the setup cycle, held through access
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (ctl_hit[2]) begin
        prdata <= {24'h00_0000, ctl_q[ctl_hit[1:0]]};
      end else if (cnt_hit[2]) begin
        prdata <= {16'h0000, cnt_w[cnt_hit[1:0]]};
      end else if (paddr == OFF_INT_STATUS) begin
        prdata <= {28'h000_0000, sts_q};
      end else if (paddr == OFF_INT_CLEAR) begin
        prdata <= 32'h0000_0000;  // Write-only, reads zero
      end else if (paddr == OFF_INT_ENABLE) begin
        prdata <= {28'h000_0000, ien_q};
      end else begin
        pslverr <= 1'b1;
      end
    end
  end

  // Control word writes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        ctl_q[i] <= CTRL_RESET;
      end
    end else if (wr_en && ctl_hit[2]) begin
      ctl_q[ctl_hit[1:0]] <= pwdata[7:0];
    end
  end

  // Interrupt enable writes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ien_q <= INT_RESET;
    end else if (wr_en && paddr == OFF_INT_ENABLE) begin
      ien_q <= pwdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky pending flags and interrupt

  // A flag step in the clearing cycle survives: set wins over clear
  always_comb begin
    sts_d = sts_q;
    if (wr_en && paddr == OFF_INT_CLEAR) begin
      sts_d = sts_d & ~pwdata[3:0];
    end
    sts_d = sts_d | ovf_w;  // [RL3] [RL4]
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sts_q <= INT_RESET;
    end else begin
      sts_q <= sts_d;
    end
  end

  // Registered level, one cycle behind the status it reflects
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(sts_q & ien_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External clock pins

  // Two-flop synchroniser, the third stage only feeds the edge detect
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ext_s1_q <= 4'h0;
      ext_s2_q <= 4'h0;
      ext_s3_q <= 4'h0;
    end else begin
      ext_s1_q <= ext_clk;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-timer clock path and counter

  for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_timer
    logic [PRE_W-1:0] pre_q;
    logic [1:0]       src_sel;
    logic             rise;
    logic             fall;
    logic             is_upper;
    logic             cat;
    logic             evt;

    assign src_sel  = ctl_q[i][CTRL_SRC_LO +: 2];
    assign rise     = ext_s2_q[i] && !ext_s3_q[i];
    assign fall     = !ext_s2_q[i] && ext_s3_q[i];
    assign is_upper = (i % 2) == 1;
    assign cat      = is_upper && ctl_q[i][CTRL_CONCAT_BIT];

    // Clock-source select ahead of the prescaler
    always_comb begin
      case (src_sel)  // [RL6]
        SRC_INTERNAL: evt = 1'b1;
        SRC_PIN_RISE: evt = rise;
        SRC_PIN_FALL: evt = fall;
        default:      evt = rise || fall;
      endcase
    end

    // Local select result, so no two processes write one shared vector
    assign src_evt[i] = evt;

    // Prescaler divides the selected source by 2^n
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        pre_q <= '0;
      end else if (!ctl_q[i][CTRL_EN_BIT]) begin
        pre_q <= '0;
      end else if (src_evt[i]) begin
        pre_q <= pre_q + PRE_W'(1);  // [RL6]
      end
    end

    assign pre_tick[i] = ctl_q[i][CTRL_EN_BIT] && src_evt[i] &&
                         ((pre_q & pre_mask(ctl_q[i][CTRL_PRE_LO +: 3])) ==
                          pre_mask(ctl_q[i][CTRL_PRE_LO +: 3]));

    // Bit 7 picks lower overflow past the prescaler, or the prescaler output
    if (i % 2 == 1) begin : g_upper
      assign tick_w[i] = cat ? (ovf_w[i-1] && ctl_q[i][CTRL_EN_BIT])  // [RL5] [RL7]
                             : pre_tick[i];                           // [RL7]
      // Concatenated pair counts in the lower timer's direction
      assign up_w[i]   = cat ? ctl_q[i-1][CTRL_DIR_BIT]   // [RL1] [RL2]
                             : ctl_q[i][CTRL_DIR_BIT];
    end else begin : g_lower
      assign tick_w[i] = pre_tick[i];
      assign up_w[i]   = ctl_q[i][CTRL_DIR_BIT];          // [RL1] [RL2]
    end

    assign load_w[i]        = wr_en && cnt_hit[2] && (cnt_hit[1:0] == 2'(i));
    assign tif[i].tick      = tick_w[i];
    assign tif[i].up        = up_w[i];
    assign tif[i].load      = load_w[i];
    assign tif[i].load_val  = pwdata[15:0];
    assign cnt_w[i]         = tif[i].count;
    assign ovf_w[i]         = tif[i].ovf;

    updown_counter u_cnt (
      .clk   (clk),
      .reset (reset),
      .bus   (tif[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_lower_flag;
    ovf_w[0] && !(wr_en && paddr == OFF_INT_CLEAR);
  endsequence

  a_dir_pair_one: assert property (  // [RL1]
    @(posedge clk) disable iff (reset)
    ctl_q[1][7] |-> (up_w[1] == ctl_q[0][6]) && (up_w[0] == ctl_q[0][6]))
    else $error("pair one direction not from timer one");

  a_dir_pair_two: assert property (  // [RL2]
    @(posedge clk) disable iff (reset)
    ctl_q[3][7] |-> (up_w[3] == ctl_q[2][6]) && (up_w[2] == ctl_q[2][6]))
    else $error("pair two direction not from timer three");

  a_flag_sticky: assert property (  // [RL3]
    @(posedge clk) disable iff (reset)
    s_lower_flag |=> sts_q[0] ##1 (irq == ien_q[0] || $past(ien_q[0]) != ien_q[0]))
    else $error("flag step did not set pending bit");

  a_cascade_bypass: assert property (  // [RL5]
    @(posedge clk) disable iff (reset)
    (ctl_q[1][7] && ctl_q[1][5]) |-> (tick_w[1] == ovf_w[0]))
    else $error("timer two not stepped by timer one overflow");

  a_prescaler_source: assert property (  // [RL6]
    @(posedge clk) disable iff (reset)
    (ctl_q[1][5] && ctl_q[1][4:3] == 2'h0 && ctl_q[1][2:0] == 3'h0)
      |-> pre_tick[1])
    else $error("prescaler not fed by internal source");

  a_select_prescaled: assert property (  // [RL7]
    @(posedge clk) disable iff (reset)
    !ctl_q[1][7] |-> (tick_w[1] == pre_tick[1]))
    else $error("timer two not clocked by its prescaler");

  a_down_pending: assert property (  // [RL4]
    @(posedge clk) disable iff (reset)
    (tick_w[2] && !up_w[2] && !load_w[2] && cnt_w[2] == 16'h0001) |=> sts_q[2])
    else $error("down step to zero did not pend");

  // Prescaler ticks must not reach a concatenated timer two
  a_cascade_hold: assert property (  // [RL5]
    @(posedge clk) disable iff (reset)
    (ctl_q[1][7] && !ovf_w[0] && !load_w[1]) |=> $stable(cnt_w[1]))
    else $error("concatenated timer two stepped without overflow");

endmodule : cascadable_updown_timer_pairs
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the cascadable up/down timer pairs
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin num_errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
  import timer_pkg::*;
  logic        clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        err;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [3:0]  ext_clk;
  int          num_errors = 0;
  int          cmp_count  = 0;
  logic [7:0]  src_ctrl [4] = '{8'h68, 8'h70, 8'h78, 8'h69};
  int          src_np   [4] = '{1, 1, 1, 4};
  logic [31:0] src_ex   [4] = '{32'h1, 32'h1, 32'h2, 32'h2};

  cascadable_updown_timer_pairs #(.PRE_W(7)) i_cascadable_updown_timer_pairs (
    .clk(clk), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clk(ext_clk), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, shared by the main sequence and the watchdog
  task automatic final_report();
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  // One APB transfer; waits on pready, never assumes its latency
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // A slave that never answers is ended by the watchdog
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next setup never lands on the release
    @(posedge clk);
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex, input string nm);
    apb(a, 1'b0, 32'h0);
    `CHECK(nm, ex, rd);
  endtask : rd_chk

  function automatic logic [7:0] ctl(input int i);
    return OFF_CTRL_BASE + 8'(4 * i);
  endfunction : ctl

  function automatic logic [7:0] cnt(input int i);
    return OFF_COUNT_BASE + 8'(4 * i);
  endfunction : cnt

  // Disable first so the load is not raced by a step
  task automatic cfg(input int i, input logic [7:0] c, input logic [15:0] v);
    apb(ctl(i), 1'b1, 32'h0);
    apb(cnt(i), 1'b1, {16'h0, v});
    apb(ctl(i), 1'b1, {24'h0, c});
  endtask : cfg

  // Wide pulses, well past the pin synchroniser delay
  task automatic pulse(input int i, input int n);
    repeat (n) begin
      ext_clk[i] <= 1'b1;
      repeat (5) @(posedge clk);
      ext_clk[i] <= 1'b0;
      repeat (5) @(posedge clk);
    end
  endtask : pulse

  task automatic step(input int i, input logic [15:0] ec, input logic [31:0] es);
    apb(OFF_INT_CLEAR, 1'b1, 32'hF);
    pulse(i, 1);
    rd_chk(cnt(i), {16'h0, ec}, "count");
    rd_chk(OFF_INT_STATUS, es, "status");
  endtask : step

  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #400000;
    num_errors++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext_clk = 4'h0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      rd_chk(ctl(i), 32'h0, "ctrl reset");
      rd_chk(cnt(i), 32'h0, "count reset");
    end
    `CHECK("mapped no error", 1'b0, err);
    apb(8'h40, 1'b1, 32'hFF);
    `CHECK("unmapped error", 1'b1, err);
    $display("test reset done");
    // Up count: only FFFE to FFFF flags; irq follows the enable mask
    apb(OFF_INT_ENABLE, 1'b1, 32'h1);
    rd_chk(OFF_INT_ENABLE, 32'h1, "enable readback");
    cfg(0, 8'h68, 16'hFFFD);
    step(0, 16'hFFFE, 32'h0);
    step(0, 16'hFFFF, 32'h1);
    `CHECK("irq set", 1'b1, irq);
    apb(OFF_INT_ENABLE, 1'b1, 32'h0);
    // Registered level drops at the edge the task returns on; look one later
    @(posedge clk);
    `CHECK("irq masked", 1'b0, irq);
    step(0, 16'h0000, 32'h0);
    $display("test up flag done");
    // Down count: 0001 to 0000 flags, the wrap to FFFF does not
    cfg(0, 8'h28, 16'h0002);
    step(0, 16'h0001, 32'h0);
    step(0, 16'h0000, 32'h1);
    step(0, 16'hFFFF, 32'h0);
    $display("test down flag done");
    // Upper timer: down and divide by 2, but must follow the lower timer
    for (int p = 0; p < 4; p += 2) begin
      cfg(p + 1, 8'hA9, 16'h0005);
      cfg(p, 8'h68, 16'hFFFE);
      pulse(p + 1, 2);
      step(p, 16'hFFFF, 32'(1 << p));
      rd_chk(cnt(p + 1), 32'h6, "upper up");
      cfg(p, 8'h28, 16'h0001);
      step(p, 16'h0000, 32'(1 << p));
      rd_chk(cnt(p + 1), 32'h5, "upper down");
      apb(ctl(p + 1), 1'b1, 32'h0);
    end
    $display("test concatenation done");
    // Timer two alone: each source code, then prescaler after the select
    for (int k = 0; k < 4; k++) begin
      cfg(1, src_ctrl[k], 16'h0000);
      pulse(1, src_np[k]);
      rd_chk(cnt(1), src_ex[k], "source step");
    end
    cfg(1, 8'h67, 16'h0000);
    repeat (40) @(posedge clk);
    apb(ctl(1), 1'b1, 32'h0);
    rd_chk(cnt(1), 32'h0, "internal divided");
    cfg(1, 8'h60, 16'h0000);
    repeat (40) @(posedge clk);
    apb(ctl(1), 1'b1, 32'h0);
    apb(cnt(1), 1'b0, 32'h0);
    `CHECK("internal runs", 1'b1, rd[15:0] > 16'd30);
    $display("test clock path done");
    final_report();
  end
endmodule : tb_top
`default_nettype wire
